/* File: pkg/xie_pkg.sv */
// Package: encodings, widths and reset values for the XOR instruction executor
package xie_pkg;
    localparam int          INSTR_W        = 14;                 // Program word width
    localparam int          DATA_W         = 8;                  // Data path width
    localparam int          FADDR_W        = 7;                  // File register address width
    localparam int          OPC_MSB        = 13;                 // Opcode field top bit
    localparam int          OPC_LSB        = 8;                  // Opcode field bottom bit
    localparam int          DEST_BIT       = 7;                  // Destination select position
    localparam logic [5:0]  OPC_LIT_XOR    = 6'h3A;              // 11 1010
    localparam logic [5:0]  OPC_REG_XOR    = 6'h06;              // 00 0110
    localparam logic [7:0]  ACC_RST        = 8'h00;              // Accumulator after reset
    localparam logic        ZERO_RST       = 1'b0;               // Zero flag after reset
    localparam logic [7:0]  DATA_ZERO      = 8'h00;              // Zero result value
    localparam int          EXEC_CYCLES    = 1;                  // Cycles per instruction

    // Decoded instruction class
    typedef enum logic [1:0] {
        XIE_NONE    = 2'b00,
        XIE_LIT_XOR = 2'b01,
        XIE_REG_XOR = 2'b10
    } xie_op_e;
endpackage

/* File: rtl/xie_decode.sv */
// Combinational decoder that classifies a program word
`timescale 1ns/1ps
module xie_decode
    import xie_pkg::*;
(
    input  wire logic [INSTR_W-1:0] instr,
    output xie_op_e                 opClass
);
    // Match the top six bits against the two XOR opcodes
    always_comb begin
        case (instr[OPC_MSB:OPC_LSB])
            OPC_LIT_XOR: opClass = XIE_LIT_XOR; // RULE1
            OPC_REG_XOR: opClass = XIE_REG_XOR; // RULE3
            default:     opClass = XIE_NONE;
        endcase
    end
endmodule

/* File: rtl/xie_top.sv */
// XOR instruction executor: literal and file register forms
// Contract
// RULE1: Opcode 111010 XORs literal with accumulator
// RULE2: Literal result written back into accumulator
// RULE3: Opcode 000110 XORs file register with accumulator
// RULE4: Destination zero writes accumulator, register untouched
// RULE5: Destination one writes register, accumulator untouched
// RULE6: One cycle each; only zero flag updated
`timescale 1ns/1ps
module xie_top
    import xie_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               instrValid,
    input  wire logic [INSTR_W-1:0] instr,
    input  wire logic [DATA_W-1:0]  fileRdData,
    output logic [FADDR_W-1:0]      fileAddr_r,
    output logic [DATA_W-1:0]       fileWrData_r,
    output logic                    fileWrEn_r,
    output logic [DATA_W-1:0]       acc_r,
    output logic                    zeroFlag_r,
    output logic                    done_r
);
    xie_op_e             opClass;    // Decoded class of the current word
    logic [DATA_W-1:0]   operand;    // Second operand: literal or file value
    logic [DATA_W-1:0]   result;     // XOR result
    logic                isLit;      // Literal form accepted
    logic                isReg;      // Register form accepted
    logic                destFile;   // Register form targets the file
    logic [DATA_W-1:0]   acc_nxt;    // Next accumulator value
    logic                zero_nxt;   // Next zero flag value

    // Classification lives in its own leaf so other executors can share it
    xie_decode uDecode (
        .instr   (instr),
        .opClass (opClass)
    );

    // Operand select and result; file read data is same-cycle, combinational
    always_comb begin
        isLit    = instrValid && (opClass == XIE_LIT_XOR);
        isReg    = instrValid && (opClass == XIE_REG_XOR);
        destFile = instr[DEST_BIT];
        operand  = isLit ? instr[DATA_W-1:0] : fileRdData; // RULE1
        result   = acc_r ^ operand;                         // RULE1 RULE3
    end

    // Accumulator destination selection
    always_comb begin
        acc_nxt = acc_r;
        if (isLit) begin
            acc_nxt = result;           // RULE2
        end else if (isReg && !destFile) begin
            acc_nxt = result;           // RULE4
        end
    end

    // Zero flag follows any executed XOR, untouched otherwise
    always_comb begin
        zero_nxt = zeroFlag_r;
        if (isLit || isReg) begin
            zero_nxt = (result == DATA_ZERO); // RULE6
        end
    end

    // Accumulator and status register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r      <= ACC_RST;
            zeroFlag_r <= ZERO_RST;
        end else begin
            acc_r      <= acc_nxt;
            zeroFlag_r <= zero_nxt;     // RULE6
        end
    end

    // File write port: registered, one cycle pulse per write-back
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fileWrEn_r   <= 1'b0;
            fileAddr_r   <= '0;
            fileWrData_r <= DATA_ZERO;
        end else begin
            fileWrEn_r   <= isReg && destFile;        // RULE5 RULE4
            fileAddr_r   <= instr[FADDR_W-1:0];       // RULE3
            fileWrData_r <= result;                   // RULE5
        end
    end

    // Completion strobe: each XOR finishes in a single cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= isLit || isReg;   // RULE6
        end
    end

    // Assertions
    // Apart from the two decode checks, they check the registered result one edge after the taking edge.
    // Operands are read back through $past, so forwarding between
    // back-to-back words is covered as well.
    // Literal form: the accumulator takes acc XOR k
    AST_LIT_ACC: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        isLit |=> acc_r == ($past(acc_r) ^ $past(instr[7:0])))
        else $error("Literal XOR result not in accumulator");
    // Register form, accumulator destination: no file write may follow
    AST_REG_ACC: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        (isReg && !destFile) |=> (acc_r == ($past(acc_r) ^ $past(fileRdData))) && !fileWrEn_r)
        else $error("Register XOR to accumulator wrong");
    // Register form, file destination: accumulator holds, file gets result
    AST_REG_FILE: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        (isReg && destFile) |=> fileWrEn_r && acc_r == $past(acc_r)
            && fileWrData_r == ($past(acc_r) ^ $past(fileRdData)))
        else $error("Register XOR to file wrong");
    AST_FILE_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        (isReg && destFile) |=> fileAddr_r == $past(instr[6:0]))
        else $error("File write address wrong");
    // Zero flag mirrors the result of the executed word
    AST_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        (isLit || isReg) |=> zeroFlag_r == ($past(result) == DATA_ZERO))
        else $error("Zero flag wrong after XOR");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        !(isLit || isReg) |=> $stable(acc_r) && $stable(zeroFlag_r) && !fileWrEn_r && !done_r)
        else $error("State changed without XOR");
    // Completion strobe is a single-cycle pulse per executed word
    AST_DONE: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        (isLit || isReg) |=> done_r ##1 (done_r == $past(isLit || isReg)))
        else $error("Completion strobe wrong");
    // Decode checks tie the raw opcode field to the accepted class
    AST_DECODE: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        (instrValid && instr[OPC_MSB:OPC_LSB] == OPC_LIT_XOR) |-> isLit && !isReg)
        else $error("Literal opcode not recognised");
    AST_DECODE_REG: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        (instrValid && instr[OPC_MSB:OPC_LSB] == OPC_REG_XOR) |-> isReg && !isLit)
        else $error("Register opcode not recognised");
    // A literal word never raises the file write strobe
    AST_LIT_NOWR: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        isLit |=> !fileWrEn_r)
        else $error("File write after literal XOR");
    // Each form completes in one cycle
    AST_LIT_DONE: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        isLit |=> done_r)
        else $error("Literal XOR did not complete in one cycle");
    AST_REG_DONE: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        isReg |=> done_r)
        else $error("Register XOR did not complete in one cycle");
    // File strobe only ever follows a file-destination register word
    AST_IDLE_FILE: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        !(isReg && destFile) |=> !fileWrEn_r)
        else $error("Unexpected file write strobe");

    // Main scenarios: each form, each destination, a zero result, back to back

    COV_LIT:  cover property (@(posedge clk) disable iff (!rst_n) isLit);
    COV_RACC: cover property (@(posedge clk) disable iff (!rst_n) isReg && !destFile);
    COV_RF:   cover property (@(posedge clk) disable iff (!rst_n) isReg && destFile);
    COV_ZERO: cover property (@(posedge clk) disable iff (!rst_n) (isLit || isReg) ##1 zeroFlag_r);
    COV_B2B:  cover property (@(posedge clk) disable iff (!rst_n) isLit ##1 isLit);
endmodule

/* File: sim/tb.sv */
// Self-checking testbench for the XOR instruction executor
`timescale 1ns/1ps
module tb import xie_pkg::*;;
    logic clk = 0, rst_n = 0, instrValid = 0;   // Bench-driven controls
    logic [13:0] instr = '0;                    // Program word under test
    logic [7:0]  fileRdData, fileWrData, acc, accExp;
    logic [6:0]  fileAddr;
    logic        fileWrEn, zeroFlag, done;
    int          fails = 0, comparisons = 0;
    xie_top uut (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instr(instr), .fileRdData(fileRdData),
        .fileAddr_r(fileAddr), .fileWrData_r(fileWrData), .fileWrEn_r(fileWrEn), .acc_r(acc),
        .zeroFlag_r(zeroFlag), .done_r(done));
    xie_file_model model (.clk(clk), .rdAddr(instr[6:0]), .rdData(fileRdData), .wrAddr(fileAddr),
        .wrData(fileWrData), .wrEn(fileWrEn));
    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One word presented for one edge; outputs sampled after they settle
    task automatic issue(input logic [13:0] w, input logic v);
        @(posedge clk);
        instrValid <= v;
        instr <= w;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask
    task automatic t_lit(input logic [7:0] k);
        issue({6'h3A, k}, 1'b1);
        accExp = accExp ^ k;
        cmp(acc, accExp);
        cmp({7'h00, zeroFlag}, {7'h00, accExp === 8'h00});
        cmp({7'h00, done}, 8'h01);
    endtask
    task automatic t_reg(input logic [6:0] f, input logic d);
        logic [7:0] r;
        r = accExp ^ {1'b0, f} ^ 8'h5A;
        issue({6'h06, d, f}, 1'b1);
        cmp(acc, d ? accExp : r);
        cmp({7'h00, fileWrEn}, {7'h00, d});
        cmp({7'h00, zeroFlag}, {7'h00, r === 8'h00});
        if (d) begin
            cmp({1'b0, fileAddr}, {1'b0, f});
            @(posedge clk);
            #1;
            cmp(model.mem[f], r);
        end else begin
            accExp = r;
        end
    endtask
    // Ignored words and idle cycles must leave accumulator, zero flag, done and file strobe alone
    task automatic t_refuse(input logic [13:0] w, input logic v);
        logic z;
        z = zeroFlag;
        issue(w, v);
        cmp(acc, accExp);
        cmp({7'h00, zeroFlag}, {7'h00, z});
        cmp({6'h00, done, fileWrEn}, 8'h00);
    endtask
    // Two literal words on consecutive edges, second uses the first's result
    task automatic t_b2b;
        @(posedge clk);
        instrValid <= 1'b1;
        instr <= 14'h3A0F;
        @(posedge clk);
        instr <= 14'h3AF0;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
        accExp = accExp ^ 8'hFF;
        cmp(acc, accExp);
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog well beyond the roughly 30 cycles the run needs
    initial begin
        #50000;
        fails++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        accExp = ACC_RST;
        t_lit(8'hB5);
        t_lit(8'hAF);
        t_lit(8'h1A);
        t_lit(8'hFF);
        t_reg(7'h7F, 1'b0);
        t_reg(7'h00, 1'b1);
        t_refuse(14'h0E55, 1'b1);
        t_refuse(14'h3A12, 1'b0);
        t_b2b;
        print_verdict;
    end
endmodule

/* File: sim/xie_file_model.sv */
// File register model standing behind the executor's register port
`timescale 1ns/1ps
module xie_file_model (
    input  wire logic       clk,
    input  wire logic [6:0] rdAddr,
    output logic [7:0]      rdData,
    input  wire logic [6:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrEn
);
    logic [7:0] mem [128];      // Seeded so every address holds its index XOR 5A
    // Known pattern lets the bench predict operands without reading back
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    // Same-cycle read: the executor samples the operand in its decode cycle
    assign rdData = mem[rdAddr];
    // Write lands one edge after the strobe, as a real register file would
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
endmodule
